// ===== rtl/ttp_triple_timer.sv
`timescale 1ns/1ps
`include "ttp_map.svh"
module ttp_triple_timer import ttp_pkg::*; #(
	parameter int NUM_CH = `TTP_NUM_CH
) (
	input wire logic clk_sys, // System clock 100 MHz
	input wire logic reset_n, // Async reset, active low
	input wire logic stop_mode, // Stop state: inputs ignored, outputs frozen
	input wire logic wait_mode, // Wait state: no effect on pins
	input wire ttp_ctrl_t ctrl [NUM_CH], // Per-channel control
	input wire logic [NUM_CH-1:0] irq_clr, // Pulse clears sticky count flag
	output ttp_stat_t stat [NUM_CH], // Per-channel status
	output logic [NUM_CH-1:0] irq, // Interrupt request per channel
	input wire logic [NUM_CH-1:0] timer_pin_i, // Pin input level
	output logic [NUM_CH-1:0] timer_pin_o, // Pin output level
	output logic [NUM_CH-1:0] timer_pin_oe // Pin drive enable
);
	function automatic logic is_output_mode(input ttp_mode_t m);
		return (m == TTP_MODE_TIMER) || (m == TTP_MODE_PULSE) || (m == TTP_MODE_WATCHDOG);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch // [RL1]
			logic [2:0] sync_q;
			logic level_q;
			logic [`TTP_CNT_W-1:0] cnt_q;
			logic flag_q;
			logic pin_o_q;
			logic pin_oe_q;
			wire logic stable = (sync_q[2] == sync_q[1]);
			wire logic new_level = stable ? sync_q[1] : level_q;
			wire logic ext_edge = ~stop_mode & stable & sync_q[1] & ~level_q;
			wire logic out_mode = is_output_mode(ctrl[g].mode);
			wire logic tick = ctrl[g].enable & ~stop_mode &
				(ctrl[g].ext_clk ? ext_edge : 1'b1); // [RL2] [RL9]
			wire logic hit = tick & (cnt_q + `TTP_CNT_ONE >= ctrl[g].compare);
			wire logic [`TTP_CNT_W-1:0] cnt_d = hit ? `TTP_CNT_ZERO :
				(tick ? cnt_q + `TTP_CNT_ONE : cnt_q);
			wire logic drv_d = (ctrl[g].mode == TTP_MODE_GPIO) ? ctrl[g].gpio_out :
				out_mode; // [RL5] [RL6] [RL10]
			wire logic lvl_d = (ctrl[g].mode == TTP_MODE_GPIO) ? ctrl[g].gpio_dout :
				(ctrl[g].mode == TTP_MODE_PULSE ? (pin_o_q ^ hit) :
				(hit ? ~pin_o_q : pin_o_q)); // [RL4]

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					sync_q <= 3'h0;
					level_q <= 1'b0;
				end else begin
					sync_q <= {sync_q[1:0], timer_pin_i[g]};
					if (!stop_mode) begin // [RL8]
						level_q <= new_level;
					end
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					cnt_q <= `TTP_CNT_ZERO;
					flag_q <= 1'b0;
					pin_o_q <= 1'b0;
					pin_oe_q <= 1'b0; // [RL7]
				end else begin
					if (ctrl[g].mode == TTP_MODE_GPIO || !ctrl[g].enable) begin
						cnt_q <= `TTP_CNT_ZERO;
					end else begin
						cnt_q <= cnt_d;
					end
					if (hit && ctrl[g].mode != TTP_MODE_GPIO) begin
						flag_q <= 1'b1; // [RL3]
					end else if (irq_clr[g]) begin
						flag_q <= 1'b0;
					end
					if (!stop_mode) begin // [RL8] [RL9]
						pin_o_q <= lvl_d;
						pin_oe_q <= drv_d;
					end
				end
			end

			assign timer_pin_o[g] = pin_o_q;
			assign timer_pin_oe[g] = pin_oe_q;
			assign irq[g] = flag_q & ctrl[g].irq_en; // [RL3]
			assign stat[g] = '{irq_flag: flag_q, pin_level: level_q, count: cnt_q};
		end
	endgenerate
endmodule

// ===== rtl/ttp_map.svh
// Summary of operation
// RL1 - Three identical independent channels, own pins
// RL2 - Counter clocked by internal clock or pin
// RL3 - Interrupt after programmed event count
// RL4 - Or drive pin after programmed count
// RL5 - Event counter, measurement: pin input only
// RL6 - Watchdog, timer, pulse modes: pin output
// RL7 - Reset: pin is general-purpose input
// RL8 - Stop: inputs ignored, outputs hold level
// RL9 - Wait state leaves pins unchanged
// RL10 - Control register: mode, source, direction, enable
`ifndef TTP_MAP_SVH
`define TTP_MAP_SVH
`define TTP_NUM_CH 3
`define TTP_CNT_W 24
`define TTP_CNT_ONE 24'h000001
`define TTP_CNT_ZERO 24'h000000
`endif

// ===== rtl/ttp_pkg.sv
package ttp_pkg;
	typedef enum logic [2:0] {
		TTP_MODE_GPIO,
		TTP_MODE_TIMER,
		TTP_MODE_PULSE,
		TTP_MODE_WATCHDOG,
		TTP_MODE_EVENT,
		TTP_MODE_MEASURE
	} ttp_mode_t;
	typedef struct packed {
		ttp_mode_t mode;
		logic      ext_clk;
		logic      gpio_out;
		logic      gpio_dout;
		logic      irq_en;
		logic      enable;
		logic [23:0] compare;
	} ttp_ctrl_t;
	typedef struct packed {
		logic        irq_flag;
		logic        pin_level;
		logic [23:0] count;
	} ttp_stat_t;
endpackage

// ===== dv/ttp_ext_dev.sv
`timescale 1ns/1ps
module ttp_ext_dev (
	input wire logic clk_sys, // Paces events
	input wire logic [2:0] timer_pin_oe, // Drive enables
	input wire logic [2:0] timer_pin_o, // Drive levels
	output logic [2:0] timer_pin_i // Pin levels
);
	logic [2:0] ev_q = 3'h0;
	always @(posedge clk_sys) ev_q <= ev_q + 3'h1;
	assign timer_pin_i = (timer_pin_oe & timer_pin_o) | (~timer_pin_oe & {3{ev_q[2]}});
endmodule

// ===== dv/ttp_chk.sv
`timescale 1ns/1ps
module ttp_chk import ttp_pkg::*; #(parameter int NUM_CH = 3) (
	input wire logic clk_sys, // Clock
	input wire logic reset_n, // Reset
	input wire logic stop_mode, // Stop
	input wire ttp_ctrl_t ctrl [NUM_CH], // Control
	input wire ttp_stat_t stat [NUM_CH], // Status
	input wire logic [NUM_CH-1:0] irq, // Irq
	input wire logic [NUM_CH-1:0] irq_clr, // Clear
	input wire logic [NUM_CH-1:0] timer_pin_o, // Level
	input wire logic [NUM_CH-1:0] timer_pin_oe // Drive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_irq_flag: assert property (irq[0] |-> stat[0].irq_flag) else $error("irq");
	a_flag_stick: assert property (stat[0].irq_flag && !irq_clr[0] |=> stat[0].irq_flag)
		else $error("flag");
	a_oe_in: assert property (ctrl[0].mode == TTP_MODE_EVENT && !stop_mode |=> !timer_pin_oe[0])
		else $error("oe");
	a_oe_out: assert property (ctrl[0].mode == TTP_MODE_TIMER && !stop_mode |=> timer_pin_oe[0])
		else $error("oe");
	a_oe_rst: assert property ($past(!reset_n) |-> timer_pin_oe == 0) else $error("oe");
	a_stop_pin: assert property (stop_mode |=> $stable(timer_pin_o) && $stable(timer_pin_oe))
		else $error("pin");
	a_gpio_cnt: assert property (ctrl[0].mode == TTP_MODE_GPIO |=> stat[0].count == 24'h000000)
		else $error("count");
	a_stop_cnt: assert property (stop_mode && ctrl[0].mode != TTP_MODE_GPIO |=> $stable(stat[0].count))
		else $error("count");
endmodule
bind ttp_triple_timer ttp_chk #(.NUM_CH(NUM_CH)) i_chk (.*);

// ===== dv/test_ttp_triple_timer.sv
`timescale 1ns/1ps
module test_ttp_triple_timer import ttp_pkg::*;;
	logic clk_sys = 0, reset_n = 0, stop_mode = 0, wait_mode = 1;
	logic [2:0] irq_clr = 0, irq, timer_pin_i, timer_pin_o, timer_pin_oe, q[$];
	ttp_ctrl_t ctrl [3] = '{default: '0};
	ttp_stat_t stat [3];
	int err_count = 0, tests_run = 0, seed = 42458, cmp;
	logic [23:0] held_cnt;
	ttp_triple_timer i_dut (.*);
	ttp_ext_dev i_dev (.*);
	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#20000;
		err_count++;
		summarize();
	end
	task summarize;
		$display("errors %0d of %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(string n, logic [2:0] e, s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %b got %b", n, e, s);
		end
	endtask
	task chk_w(string n, logic [23:0] e, s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task set(ttp_mode_t m, logic x, logic [2:0] ie);
		@(posedge clk_sys);
		#1;
		foreach (ctrl[i]) ctrl[i] = '{m, x, 1'b0, 1'b0, ie[i], 1'b1, 24'(cmp)};
	endtask
	always @(irq) begin
		if (irq !== 3'h0) begin
			if (q.size() > 0) chk("irq", q.pop_front(), irq);
			else chk("irq", 3'h0, irq);
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 reset_n = 1;
		chk("oe", 3'h0, timer_pin_oe);
		cmp = 2 + {$random(seed)} % 8;
		q.push_back(3'h7);
		set(TTP_MODE_TIMER, 0, 3'h7);
		repeat (12) @(negedge clk_sys);
		chk("oe", 3'h7, timer_pin_oe);
		set(TTP_MODE_GPIO, 0, 3'h0);
		irq_clr = 3'h7;
		set(TTP_MODE_EVENT, 1, 3'h2);
		irq_clr = 3'h0;
		chk_w("count", 24'h000000, stat[0].count);
		wait_mode = $random(seed);
		q.push_back(3'h2);
		repeat (100) @(negedge clk_sys);
		chk("oe", 3'h0, timer_pin_oe);
		chk("irqs", 3'h0, 3'(q.size()));
		@(posedge clk_sys);
		#1 stop_mode = 1;
		@(posedge clk_sys);
		#1 held_cnt = stat[1].count;
		repeat (4) @(posedge clk_sys);
		#1 chk_w("count", held_cnt, stat[1].count);
		chk("oe", 3'h0, timer_pin_oe);
		summarize();
	end
endmodule
